// File: lwc_pkg.sv
// Purpose: Shared constants and types for the display command decoder
// Assumes: AHB-Lite register access, 32-bit words
// Notes:   Offsets are byte addresses
package lwc_pkg;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] OFS_CMD     = 8'h00;
    localparam logic [7:0] OFS_DATA    = 8'h04;
    localparam logic [7:0] OFS_ADDR    = 8'h08;
    localparam logic [7:0] OFS_WINDOW  = 8'h0c;
    localparam logic [7:0] OFS_SCAN    = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;
    localparam logic [7:0] OFS_SLOT    = 8'h18;

    // ********************************************************
    // Opcodes
    // ********************************************************
    localparam logic [7:0] OP_COL_LSB  = 8'h00;
    localparam logic [7:0] OP_COL_MSB  = 8'h10;
    localparam logic [7:0] OP_PAGE     = 8'h60;
    localparam logic [7:0] OP_POT      = 8'h81;
    localparam logic [7:0] OP_PARTIAL  = 8'h84;
    localparam logic [7:0] OP_ADDRCTL  = 8'h88;
    localparam logic [7:0] OP_MAPPING  = 8'hc0;
    localparam logic [7:0] OP_TEST     = 8'he4;
    localparam logic [7:0] OP_BIAS     = 8'he8;
    localparam logic [7:0] OP_CURSOR   = 8'hee;
    localparam logic [7:0] OP_COM_END  = 8'hf1;
    localparam logic [7:0] OP_PART_BEG = 8'hf2;
    localparam logic [7:0] OP_PART_END = 8'hf3;
    localparam logic [7:0] OP_WCOL_BEG = 8'hf4;
    localparam logic [7:0] OP_WPAG_BEG = 8'hf5;
    localparam logic [7:0] OP_WCOL_END = 8'hf6;
    localparam logic [7:0] OP_WPAG_END = 8'hf7;
    localparam logic [7:0] OP_WIN_EN   = 8'hf8;

    // ********************************************************
    // Reset values, mirror base and partial mode codes
    // ********************************************************
    localparam logic [7:0] RST_COM_END  = 8'h7f;
    localparam logic [7:0] RST_PART_END = 8'h7f;
    localparam logic [7:0] RST_WCOL_END = 8'h9f;
    localparam logic [4:0] RST_WPAG_END = 5'h1f;
    localparam logic [7:0] MIRROR_BASE  = 8'h7f;
    localparam logic [1:0] PART_OFF_ALL = 2'b10;
    localparam logic [1:0] PART_NARROW  = 2'b11;

    typedef enum logic [1:0]
    {
        ST_OPCODE = 2'b00,
        ST_PARAM  = 2'b01
    } lwc_state_type;

    typedef struct packed
    {
        logic [7:0] col_begin;
        logic [7:0] col_finish;
        logic [4:0] page_begin;
        logic [4:0] page_finish;
    } lwc_window_type;

    typedef struct packed
    {
        logic       cursor_mode;
        logic       window_en;
        logic       page_direction;
        logic       increment_order;
        logic       wrap_enable;
    } lwc_addrctl_type;

endpackage : lwc_pkg

// File: lwc_ctrl.sv
// Purpose: Command decoder with cursor, partial display and window address logic
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   Notes on behaviour list below
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

module lwc_ctrl
#(
    parameter int COL_MAX  = 159,
    parameter int PAGE_MAX = 31
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  scan_row,
    output logic             scan_pulse,
    output logic             scan_slot
);

    // ********************************************************
    // Bus slave
    // ********************************************************
    logic        ph_wr_r;
    logic        ph_rd_r;
    logic [7:0]  ph_addr_r;
    wire         take = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr_r   <= 1'b0;
            ph_rd_r   <= 1'b0;
            ph_addr_r <= 8'h00;
        end
        else
        begin
            ph_wr_r   <= take & hwrite;
            ph_rd_r   <= take & ~hwrite;
            ph_addr_r <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire wr_cmd  = ph_wr_r && (ph_addr_r == lwc_pkg::OFS_CMD);
    wire wr_data = ph_wr_r && (ph_addr_r == lwc_pkg::OFS_DATA);
    wire rd_data = ph_rd_r && (ph_addr_r == lwc_pkg::OFS_DATA);
    wire [7:0] cbyte = hwdata[7:0];

    // ********************************************************
    // Control state
    // ********************************************************
    lwc_pkg::lwc_state_type   state_r;
    logic [7:0]               op_r;
    lwc_pkg::lwc_window_type  win_r;
    lwc_pkg::lwc_addrctl_type ac_r;
    logic [7:0]               common_last_index_r;
    logic [7:0]               partial_first_row_r;
    logic [7:0]               partial_last_row_r;
    logic [1:0]               partial_mode_r;
    logic [1:0]               bias_ratio_select_r;
    logic [7:0]               bias_potentiometer_r;
    logic                     column_mirror_r;
    logic [7:0]               column_pointer_r;
    logic [4:0]               page_pointer_r;
    logic [7:0]               saved_column_r;
    logic [7:0]               column_pointer_nxt;
    logic [4:0]               page_pointer_nxt;
    logic [7:0]               ram_data_r;

    wire in_op    = wr_cmd && (state_r == lwc_pkg::ST_OPCODE);
    wire in_param = wr_cmd && (state_r == lwc_pkg::ST_PARAM);
    wire two_byte = (cbyte == lwc_pkg::OP_POT) || (cbyte[7:2] == lwc_pkg::OP_TEST[7:2])
                 || (cbyte[7:3] == 5'b11110);
    wire op_cursor = in_op && (cbyte[7:1] == lwc_pkg::OP_CURSOR[7:1]);
    wire cursor_set = op_cursor & cbyte[0];
    wire cursor_clr = op_cursor & ~cbyte[0] & ac_r.cursor_mode;

    // Bias ratio decode
    wire [3:0] bias_ratio = (bias_ratio_select_r == 2'd0) ? 4'd5 :
                            (bias_ratio_select_r == 2'd1) ? 4'd10 :
                            (bias_ratio_select_r == 2'd2) ? 4'd11 : 4'd12;

    // ********************************************************
    // Address stepping
    // ********************************************************
    // Bounds collapse to the full array when the window is off
    wire [7:0] col_lo  = ac_r.window_en ? win_r.col_begin   : 8'h00;
    wire [7:0] col_hi  = ac_r.window_en ? win_r.col_finish  : 8'(COL_MAX);
    wire [4:0] pg_beg  = ac_r.window_en ? win_r.page_begin  : 5'h00;
    wire [4:0] pg_end  = ac_r.window_en ? win_r.page_finish : 5'(PAGE_MAX);
    // Page direction picks which bound the page walks toward
    wire [4:0] pg_from = ac_r.page_direction ? pg_end : pg_beg;
    wire [4:0] pg_to   = ac_r.page_direction ? pg_beg : pg_end;
    wire [4:0] pg_step = ac_r.page_direction ? (page_pointer_r - 5'd1)
                                             : (page_pointer_r + 5'd1);
    wire       col_at_end = (column_pointer_r == col_hi);
    wire       pg_at_end  = (page_pointer_r == pg_to);
    wire [7:0] col_inc    = column_pointer_r + 8'd1;

    always_comb
    begin
        column_pointer_nxt = column_pointer_r;
        page_pointer_nxt   = page_pointer_r;
        if (cursor_clr)
            column_pointer_nxt = saved_column_r;
        else if (in_op && (cbyte[7:4] == 4'h0))
            column_pointer_nxt = {column_pointer_r[7:4], cbyte[3:0]};
        else if (in_op && (cbyte[7:4] == 4'h1))
            column_pointer_nxt = {cbyte[3:0], column_pointer_r[3:0]};
        else if (in_op && (cbyte[7:5] == 3'b011))
            page_pointer_nxt = cbyte[4:0];
        else if (wr_data && ac_r.cursor_mode)
        begin
            if (!col_at_end)
                column_pointer_nxt = col_inc;
        end
        else if (wr_data || (rd_data && !ac_r.cursor_mode))
        begin
            if (!ac_r.increment_order)
            begin
                if (!col_at_end)
                    column_pointer_nxt = col_inc;
                else if (ac_r.wrap_enable)
                begin
                    column_pointer_nxt = col_lo;
                    page_pointer_nxt   = pg_at_end ? pg_from : pg_step;
                end
            end
            else
            begin
                if (!pg_at_end)
                    page_pointer_nxt = pg_step;
                else if (ac_r.wrap_enable)
                begin
                    page_pointer_nxt   = pg_from;
                    column_pointer_nxt = col_at_end ? col_lo : col_inc;
                end
            end
        end
    end

    // Mirrored column used as the physical RAM column
    wire [7:0] ram_column = column_mirror_r ? (lwc_pkg::MIRROR_BASE - column_pointer_r)
                                            : column_pointer_r;

    // ********************************************************
    // Command decode
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r              <= lwc_pkg::ST_OPCODE;
            op_r                 <= 8'h00;
            win_r                <= '{8'h00, lwc_pkg::RST_WCOL_END, 5'h00, lwc_pkg::RST_WPAG_END};
            ac_r                 <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            common_last_index_r  <= lwc_pkg::RST_COM_END;
            partial_first_row_r  <= 8'h00;
            partial_last_row_r   <= lwc_pkg::RST_PART_END;
            partial_mode_r       <= 2'b00;
            bias_ratio_select_r  <= 2'b11;
            bias_potentiometer_r <= 8'h00;
            column_mirror_r      <= 1'b0;
            column_pointer_r     <= 8'h00;
            page_pointer_r       <= 5'h00;
            saved_column_r       <= 8'h00;
            ram_data_r           <= 8'h00;
        end
        else
        begin
            column_pointer_r <= column_pointer_nxt;
            page_pointer_r   <= page_pointer_nxt;
            if (wr_data)
                ram_data_r <= hwdata[7:0];
            if (in_op && two_byte)
            begin
                state_r <= lwc_pkg::ST_PARAM;
                op_r    <= cbyte;
            end
            else if (in_param)
            begin
                state_r <= lwc_pkg::ST_OPCODE;
                if (op_r == lwc_pkg::OP_COM_END)
                    common_last_index_r <= cbyte;
                else if (op_r == lwc_pkg::OP_PART_BEG)
                    partial_first_row_r <= cbyte;
                else if (op_r == lwc_pkg::OP_PART_END)
                    partial_last_row_r <= cbyte;
                else if (op_r == lwc_pkg::OP_WCOL_BEG)
                    win_r.col_begin <= cbyte;
                else if (op_r == lwc_pkg::OP_WPAG_BEG)
                    win_r.page_begin <= cbyte[4:0];
                else if (op_r == lwc_pkg::OP_WCOL_END)
                    win_r.col_finish <= cbyte;
                else if (op_r == lwc_pkg::OP_WPAG_END)
                    win_r.page_finish <= cbyte[4:0];
                else if (op_r == lwc_pkg::OP_POT)
                    bias_potentiometer_r <= cbyte;
            end
            else if (in_op)
            begin
                if (cursor_set)
                begin
                    ac_r.cursor_mode <= 1'b1;
                    saved_column_r   <= column_pointer_r;
                end
                else if (op_cursor)
                    ac_r.cursor_mode <= 1'b0;
                else if (cbyte[7:2] == lwc_pkg::OP_BIAS[7:2])
                    bias_ratio_select_r <= cbyte[1:0];
                else if (cbyte[7:2] == lwc_pkg::OP_PARTIAL[7:2])
                    partial_mode_r <= cbyte[1:0];
                else if (cbyte[7:3] == lwc_pkg::OP_ADDRCTL[7:3])
                begin
                    ac_r.page_direction  <= cbyte[2];
                    ac_r.increment_order <= cbyte[1];
                    ac_r.wrap_enable     <= cbyte[0];
                end
                else if (cbyte[7:3] == lwc_pkg::OP_MAPPING[7:3])
                    column_mirror_r <= cbyte[1];
                else if (cbyte[7:1] == lwc_pkg::OP_WIN_EN[7:1])
                    ac_r.window_en <= cbyte[0];
            end
        end
    end

    // ********************************************************
    // Scan gating
    // ********************************************************
    wire in_part = (scan_row >= partial_first_row_r) && (scan_row <= partial_last_row_r);
    wire in_com  = (scan_row <= common_last_index_r);
    wire [7:0] mux_rate = (partial_mode_r == lwc_pkg::PART_NARROW)
                        ? (partial_last_row_r - partial_first_row_r + 8'd1)
                        : (common_last_index_r + 8'd1);

    always_comb
    begin
        scan_slot  = in_com;
        scan_pulse = in_com;
        if (partial_mode_r == lwc_pkg::PART_NARROW)
        begin
            scan_slot  = in_part;
            scan_pulse = in_part;
        end
        else if (partial_mode_r == lwc_pkg::PART_OFF_ALL)
            scan_pulse = in_com & in_part;
    end

    // ********************************************************
    // Read mux
    // ********************************************************
    wire [31:0] rd_addr = {3'b000, page_pointer_r, column_pointer_r, ram_column, saved_column_r};
    wire [31:0] rd_win  = {win_r.page_finish, 3'b000, win_r.col_finish, 3'b000, win_r.page_begin,
                           win_r.col_begin};
    wire [31:0] rd_scan = {mux_rate, partial_last_row_r, partial_first_row_r, common_last_index_r};
    wire [31:0] rd_ctl  = {4'h0, bias_potentiometer_r, 4'h0, bias_ratio, 1'b0, state_r[0],
                           partial_mode_r, column_mirror_r, bias_ratio_select_r, ac_r};
    wire [31:0] rd_slot = {30'h0, scan_slot, scan_pulse};

    wire [31:0] rd_mux = (ph_addr_r == lwc_pkg::OFS_DATA)    ? {24'h0, ram_data_r} :
                         (ph_addr_r == lwc_pkg::OFS_ADDR)    ? rd_addr :
                         (ph_addr_r == lwc_pkg::OFS_WINDOW)  ? rd_win  :
                         (ph_addr_r == lwc_pkg::OFS_SCAN)    ? rd_scan :
                         (ph_addr_r == lwc_pkg::OFS_CONTROL) ? rd_ctl  :
                         (ph_addr_r == lwc_pkg::OFS_SLOT)    ? rd_slot : 32'h0;

    assign hrdata = ph_rd_r ? rd_mux : 32'h0;

endmodule : lwc_ctrl

// File: lwc_ctrl_checker.sv
// Purpose: Port-level checks for the display command decoder
// Assumes: Zero wait state slave; scan and command state shadowed here
// Notes:   Shadow decodes the same command bytes the host sends
`timescale 1ns/1ps
module lwc_ctrl_checker
#(
    parameter int COL_MAX  = 159,
    parameter int PAGE_MAX = 31
)
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [7:0]  scan_row,
    input wire logic        scan_pulse,
    input wire logic        scan_slot
);
    // ********************************************************
    // Command shadow
    // ********************************************************
    logic       wph_r, rph_r, pend_r;
    logic [7:0] adr_r, op_r, cl_r, first_r, last_r;
    logic [1:0] mode_r;
    wire        take = hsel && hready && htrans[1];
    wire  [7:0] b    = hwdata[7:0];
    wire        cmd  = wph_r && adr_r == lwc_pkg::OFS_CMD;
    wire        inr  = scan_row >= first_r && scan_row <= last_r;
    wire        used = scan_row <= cl_r;
    wire  [7:0] mux  = (mode_r == 2'b11) ? last_r - first_r + 8'h01 : cl_r + 8'h01;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {wph_r, rph_r, pend_r, mode_r, first_r, adr_r, op_r} <= '0;
            cl_r   <= lwc_pkg::RST_COM_END;
            last_r <= lwc_pkg::RST_PART_END;
        end
        else
        begin
            wph_r <= take && hwrite;
            rph_r <= take && !hwrite;
            adr_r <= haddr[7:0];
            if (cmd)
            begin
                pend_r <= !pend_r && (b == 8'h81 || b[7:2] == 6'h39 || b[7:3] == 5'h1e);
                op_r   <= b;
                if (pend_r && op_r == lwc_pkg::OP_COM_END) cl_r <= b;
                if (pend_r && op_r == lwc_pkg::OP_PART_BEG) first_r <= b;
                if (pend_r && op_r == lwc_pkg::OP_PART_END) last_r <= b;
                if (!pend_r && b[7:2] == 6'h21) mode_r <= b[1:0];
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_scan_addr;
        take && !hwrite && haddr[7:0] == lwc_pkg::OFS_SCAN;
    endsequence
    chk_scan_fields: assert property (s_scan_addr |=> hrdata[23:0] == {last_r, first_r, cl_r})
        else $error("scan register fields differ from commands sent");
    chk_mux_rate: assert property (s_scan_addr |=> hrdata[31:24] == mux)
        else $error("multiplex rate wrong for partial mode");
    chk_narrow_slot: assert property (mode_r == 2'b11 |-> scan_slot == inr && scan_pulse == inr)
        else $error("narrowed mode scans outside partial range");
    chk_keep_slots: assert property (mode_r == lwc_pkg::PART_OFF_ALL |-> scan_slot == used)
        else $error("pulse-off mode lost time slots");
    chk_pulse_range: assert property (mode_r == lwc_pkg::PART_OFF_ALL |-> scan_pulse == (inr && used))
        else $error("pulse-off mode pulses wrong rows");
    chk_full_scan: assert property (mode_r == 2'b00 |-> scan_slot == used && scan_pulse == used)
        else $error("full scan does not follow common end");
    chk_read_quiet: assert property (!rph_r |-> hrdata == 32'h0000_0000)
        else $error("read data outside read data phase");
    chk_zero_wait: assert property (hreadyout && !hresp && $stable(hreadyout))
        else $error("slave not ready or not okay");
endmodule : lwc_ctrl_checker

bind lwc_ctrl lwc_ctrl_checker #(.COL_MAX(COL_MAX), .PAGE_MAX(PAGE_MAX)) u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .scan_row, .scan_pulse, .scan_slot);

// File: lwc_host_model.sv
// Purpose: Host processor model sending display commands over AHB-Lite
// Assumes: One slave whose hreadyout is the bus hready
// Notes:   Released write data shows the inverted last value
`timescale 1ns/1ps
module lwc_host_model
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial
    begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'b010;
    end
    // Called just after a rising edge; returns just after one
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hsel   <= 1'b0;
        hwdata <= ~{24'h000000, d};
        // One idle cycle keeps a following call from retouching hsel in this step
        @(posedge hclk);
    endtask : xfer
endmodule : lwc_host_model

// File: tb_lcd_window_cursor_partial_ctrl.sv
// Purpose: Self-checking bench for the display command decoder
// Assumes: Host model drives the bus; scan row driven here
// Notes:   Random parameters from a fixed seed
`timescale 1ns/1ps
module tb_lcd_window_cursor_partial_ctrl;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, scan_pulse, scan_slot;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [7:0]  scan_row, p, c, f, l, e, mux;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  win [4];
    int          n_mismatch, checked, cyc, k;
    localparam logic [7:0] CTL [4] = '{8'h89, 8'h8d, 8'h8b, 8'h88};
    localparam logic [7:0] PG0 [4] = '{8'd2, 8'd4, 8'd2, 8'd2};
    localparam logic [4:0] EPG [4] = '{5'd3, 5'd3, 5'd2, 5'd2};
    localparam logic [7:0] ECA [4] = '{8'd10, 8'd10, 8'd11, 8'd12};
    localparam logic [3:0] BRV [4] = '{4'd5, 4'd10, 4'd11, 4'd12};

    lwc_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .scan_row, .scan_pulse, .scan_slot);
    lwc_host_model u_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ********************************************************
    // Helpers
    // ********************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(a, 1'b1, d, q);
    endtask : wr
    task automatic cmd(input logic [7:0] d);
        wr(lwc_pkg::OFS_CMD, d);
    endtask : cmd
    task automatic set_ca(input logic [7:0] v);
        cmd({4'h0, v[3:0]});
        cmd({4'h1, v[7:4]});
    endtask : set_ca
    task automatic chk_addr(input logic [4:0] pg, input logic [7:0] ca, input logic [7:0] sv, input logic mx);
        u_host.xfer(lwc_pkg::OFS_ADDR, 1'b0, 8'h00, q);
        check(q, {3'b000, pg, ca, mx ? 8'h7f - ca : ca, sv});
    endtask : chk_addr
    function automatic logic [31:0] exp_scan(input int m, input int r);
        logic in_range;
        in_range = r >= f && r <= l;
        if (m == 3)
            return {30'h0, in_range, in_range};
        return {30'h0, r <= e, (m == 2) ? in_range && r <= e : r <= e};
    endfunction : exp_scan
    task automatic conclude;
        $display("counts: %0d checked, %0d mismatch", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    // ********************************************************
    // Tests
    // ********************************************************
    initial
    begin
        {hresetn, scan_row, n_mismatch, checked, cyc} = '0;
        win = '{8'h00, 8'h00, 8'h9f, 8'h1f};
        void'($urandom(52762));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        u_host.xfer(lwc_pkg::OFS_SCAN, 1'b0, 8'h00, q);
        check(q, 32'h807f007f);
        chk_addr(5'h00, 8'h00, 8'h00, 1'b0);
        u_host.xfer(lwc_pkg::OFS_CONTROL, 1'b0, 8'h00, q);
        check({28'h0000000, q[15:12]}, {28'h0000000, BRV[3]});
        $display("test reset done");
        // First pass uses an opcode-like parameter that must not be decoded
        for (int i = 0; i < 8; i++)
        begin
            p = (i < 4) ? 8'hf1 : 8'($urandom);
            k = i % 4;
            cmd(lwc_pkg::OP_WCOL_BEG + 8'(k));
            cmd(p);
            win[k] = k[0] ? {3'b000, p[4:0]} : p;
            u_host.xfer(lwc_pkg::OFS_WINDOW, 1'b0, 8'h00, q);
            check(q, {win[3][4:0], 3'b000, win[2], 3'b000, win[1][4:0], win[0]});
        end
        u_host.xfer(lwc_pkg::OFS_SCAN, 1'b0, 8'h00, q);
        check(q, 32'h807f007f);
        $display("test window bounds done");
        c = 8'($urandom_range(100));
        set_ca(c);
        cmd(8'hef);
        chk_addr(5'h00, c, c, 1'b0);
        repeat (3) wr(lwc_pkg::OFS_DATA, 8'($urandom));
        u_host.xfer(lwc_pkg::OFS_DATA, 1'b0, 8'h00, q);
        chk_addr(5'h00, c + 8'd3, c, 1'b0);
        cmd(8'hee);
        chk_addr(5'h00, c, c, 1'b0);
        u_host.xfer(lwc_pkg::OFS_DATA, 1'b0, 8'h00, q);
        chk_addr(5'h00, c + 8'd1, c, 1'b0);
        set_ca(8'h9f);
        cmd(8'hef);
        repeat (2) wr(lwc_pkg::OFS_DATA, 8'($urandom));
        chk_addr(5'h00, 8'h9f, 8'h9f, 1'b0);
        cmd(8'hee);
        cmd(8'hc2);
        set_ca(c);
        chk_addr(5'h00, c, 8'h9f, 1'b1);
        cmd(8'hc0);
        $display("test cursor done");
        cmd(8'hf8);
        cmd(8'hf4); cmd(8'd10); cmd(8'hf5); cmd(8'd2); cmd(8'hf6); cmd(8'd12); cmd(8'hf7); cmd(8'd4);
        for (int i = 0; i < 4; i++)
        begin
            cmd(CTL[i]);
            cmd(8'h60 | PG0[i]);
            set_ca(8'd10);
            cmd(8'hf9);
            repeat (3 + int'(i == 3)) wr(lwc_pkg::OFS_DATA, 8'($urandom));
            chk_addr(EPG[i], ECA[i], 8'h9f, 1'b0);
            cmd(8'hf8);
        end
        $display("test window stepping done");
        f = 8'($urandom_range(20));
        l = f + 8'($urandom_range(10, 3));
        e = l + 8'd5;
        cmd(8'hf1); cmd(e); cmd(8'hf2); cmd(f); cmd(8'hf3); cmd(l);
        for (int m = 0; m < 4; m++)
        begin
            if (m == 1)
                continue;
            cmd(8'h84 | 8'(m));
            mux = (m == 3) ? l - f + 8'd1 : e + 8'd1;
            if (m == 3 && mux < 8'd32)
                cmd(8'he8);
            u_host.xfer(lwc_pkg::OFS_SCAN, 1'b0, 8'h00, q);
            check(q, {mux, l, f, e});
            for (int r = 0; r <= e + 3; r++)
            begin
                @(posedge hclk);
                scan_row <= 8'(r);
                @(negedge hclk);
                check({30'h0, scan_slot, scan_pulse}, exp_scan(m, r));
            end
            @(posedge hclk);
        end
        $display("test partial done");
        for (int b = 0; b < 4; b++)
        begin
            cmd(8'he8 | 8'(b));
            u_host.xfer(lwc_pkg::OFS_CONTROL, 1'b0, 8'h00, q);
            check({28'h0000000, q[15:12]}, {28'h0000000, BRV[b]});
        end
        $display("test bias done");
        conclude();
    end
endmodule : tb_lcd_window_cursor_partial_ctrl
